// File: core/cpr_regs.sv
// Operation
// [RULE1] page register drives upper indirect move address
// [RULE2] indirect pointer register gives lower address byte
// [RULE3] arbiter grants processor and dma all spaces
// [RULE4] cache disable invalidates cache, fetches from flash
// [RULE5] prefetch next two bytes unless disabled
// [RULE6] two sixteen-bit pointers, bytes separately accessible
// [RULE7] select bit zero chooses active pointer
// [RULE8] four eight-register banks, also at 0xff00
// [RULE9] status bits 4:3 choose bank base
// [RULE10] bit 7 is carry or borrow
// [RULE11] bit 6 is nibble carry or borrow
// [RULE12] bit 2 carry, borrow or mul/div overflow
// [RULE13] bit 0 always accumulator odd parity
// [RULE14] bits 5 and 1 software only
// [RULE15] status word is bit-addressable register
// [RULE16] software write beats hardware flag update
`timescale 1ns/1ps
`default_nettype none

module cpr_regs (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_bit_wr_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic [2:0]  sfr_bit_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	input  wire logic        arith_valid_i,
	input  wire logic        arith_carry_i,
	input  wire logic        arith_half_i,
	input  wire logic        arith_ovf_i,
	input  wire logic [7:0]  acc_i,
	input  wire logic        external_data_move_ri_i,
	input  wire logic        ri_sel_i,
	input  wire logic        ptr_inc_i,
	output logic      [15:0] external_data_move_addr_o,
	output logic      [15:0] active_ptr_o,
	input  wire logic        wr_bank_wr_i,
	input  wire logic [15:0] wr_bank_addr_i,
	input  wire logic [7:0]  wr_bank_wdata_i,
	output logic      [7:0]  wr_bank_rdata_o,
	input  wire logic        cpu_req_i,
	input  wire logic        dma_req_i,
	output logic             cpu_gnt_o,
	output logic             dma_gnt_o,
	input  wire logic        fetch_i,
	input  wire logic        cache_last_i,
	output logic             cache_flush_o,
	output logic             fetch_bypass_o,
	output logic             prefetch_o
);

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function automatic logic in_window(input logic [15:0] a);
		in_window = (a >= cpr_pkg::BANK_WINDOW_BASE) &&
			(a <= cpr_pkg::BANK_WINDOW_LAST);
	endfunction

	function automatic logic [4:0] bank_index(input logic [15:0] a);
		bank_index = a[4:0];
	endfunction

	function automatic logic [4:0] ri_index(input logic [1:0] bank,
		input logic sel);
		ri_index = {bank, 2'h0, sel};
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]  dpl_q [2];
	logic [7:0]  dpl_d [2];
	logic [7:0]  dph_q [2];
	logic [7:0]  dph_d [2];
	logic [7:0]  sel_q;
	logic [7:0]  sel_d;
	logic [7:0]  page_q;
	logic [7:0]  page_d;
	logic [7:0]  psw_q;
	logic [7:0]  psw_d;
	logic [7:0]  ffc_q;
	logic [7:0]  ffc_d;
	logic [7:0]  bank_q [32];
	logic [7:0]  bank_d [32];
	logic [7:0]  rdata_d;
	logic [7:0]  bank_rdata_d;
	logic [15:0] external_data_move_d;
	logic [15:0] ptr_d;
	logic        flush_d;
	logic        bypass_d;
	logic        pref_d;
	logic        cpu_gnt_d;
	logic        dma_gnt_d;
	logic        last_dma_q;
	logic        last_dma_d;
	logic [7:0]  wmask;
	logic [7:0]  wval;
	logic [4:0]  bank_wr_idx;
	logic        bank_wr_en;
	logic        ptr_sel;
	logic [15:0] ptr_cur;

	// ----------------------------------------
	// register next state
	// ----------------------------------------
	always_comb
	begin
		// a bit write touches one bit, a byte write all eight
		wmask = sfr_bit_wr_i ? (8'h01 << sfr_bit_i) : 8'hff;
		wval  = sfr_bit_wr_i ? {8{sfr_wdata_i[0]}} : sfr_wdata_i;
		for (int i = 0; i < 2; i++)
		begin
			dpl_d[i] = dpl_q[i];
			dph_d[i] = dph_q[i];
		end
		sel_d  = sel_q;
		page_d = page_q;
		ffc_d  = ffc_q;
		psw_d  = psw_q;
		ptr_sel = sel_q[cpr_pkg::POINTER_SELECT_BIT]; // RULE7
		ptr_cur = {dph_q[ptr_sel], dpl_q[ptr_sel]};
		if (ptr_inc_i)
		begin
			ptr_cur = ptr_cur + 16'h0001;
			dpl_d[ptr_sel] = ptr_cur[7:0];
			dph_d[ptr_sel] = ptr_cur[15:8];
		end
		if (arith_valid_i)
		begin
			psw_d[cpr_pkg::PSW_CARRY]      = arith_carry_i; // RULE10
			psw_d[cpr_pkg::PSW_HALF_CARRY] = arith_half_i; // RULE11
			psw_d[cpr_pkg::PSW_OVERFLOW]   = arith_ovf_i; // RULE12
		end
		if (sfr_wr_i || sfr_bit_wr_i)
		begin
			unique case (sfr_addr_i)
				cpr_pkg::DATA_POINTER0_LOW_ADDR:
					dpl_d[0] = (dpl_d[0] & ~wmask) | (wval & wmask); // RULE6
				cpr_pkg::DATA_POINTER0_HIGH_ADDR:
					dph_d[0] = (dph_d[0] & ~wmask) | (wval & wmask); // RULE6
				cpr_pkg::DATA_POINTER1_LOW_ADDR:
					dpl_d[1] = (dpl_d[1] & ~wmask) | (wval & wmask); // RULE6
				cpr_pkg::DATA_POINTER1_HIGH_ADDR:
					dph_d[1] = (dph_d[1] & ~wmask) | (wval & wmask); // RULE6
				cpr_pkg::POINTER_SELECT_ADDR:
					sel_d = (sel_q & ~wmask) | (wval & wmask);
				cpr_pkg::XDATA_PAGE_HIGH_ADDR:
					page_d = (page_q & ~wmask) | (wval & wmask);
				cpr_pkg::FLASH_FETCH_CONTROL_ADDR:
					ffc_d = (ffc_q & ~wmask) | (wval & wmask);
				cpr_pkg::PROCESSOR_STATUS_ADDR:
					psw_d = (psw_d & ~wmask) | (wval & wmask); // RULE15 RULE16
				default:
					psw_d = psw_d;
			endcase
		end
		// parity is never stored from software
		psw_d[cpr_pkg::PSW_PARITY] = ^acc_i; // RULE13 RULE16
	end

	// ----------------------------------------
	// working banks
	// ----------------------------------------
	always_comb
	begin
		bank_wr_en  = wr_bank_wr_i && (in_window(wr_bank_addr_i) ||
			(wr_bank_addr_i[15:8] == 8'h00 &&
			wr_bank_addr_i[7:0] <= cpr_pkg::BANK_DATA_LAST)); // RULE8
		bank_wr_idx = bank_index(wr_bank_addr_i);
		for (int i = 0; i < 32; i++)
			bank_d[i] = bank_q[i];
		if (bank_wr_en)
			bank_d[bank_wr_idx] = wr_bank_wdata_i;
		bank_rdata_d = (in_window(wr_bank_addr_i) ||
			(wr_bank_addr_i[15:8] == 8'h00 &&
			wr_bank_addr_i[7:0] <= cpr_pkg::BANK_DATA_LAST)) ?
			bank_q[bank_index(wr_bank_addr_i)] : 8'h00; // RULE8
	end

	// ----------------------------------------
	// addresses, read mux, fetch and arbiter
	// ----------------------------------------
	always_comb
	begin
		// bank bits pick the pointer register's bank
		external_data_move_d = {page_q, bank_q[ri_index(
			psw_q[cpr_pkg::PSW_BANK_HI:cpr_pkg::PSW_BANK_LO],
			ri_sel_i)]}; // RULE1 RULE2 RULE9
		if (!external_data_move_ri_i)
			external_data_move_d = external_data_move_addr_o;
		ptr_d = sel_q[cpr_pkg::POINTER_SELECT_BIT] ?
			{dph_q[1], dpl_q[1]} : {dph_q[0], dpl_q[0]}; // RULE7
		unique case (sfr_addr_i)
			cpr_pkg::DATA_POINTER0_LOW_ADDR:   rdata_d = dpl_q[0];
			cpr_pkg::DATA_POINTER0_HIGH_ADDR:  rdata_d = dph_q[0];
			cpr_pkg::DATA_POINTER1_LOW_ADDR:   rdata_d = dpl_q[1];
			cpr_pkg::DATA_POINTER1_HIGH_ADDR:  rdata_d = dph_q[1];
			cpr_pkg::POINTER_SELECT_ADDR:      rdata_d = sel_q;
			cpr_pkg::XDATA_PAGE_HIGH_ADDR:     rdata_d = page_q;
			cpr_pkg::FLASH_FETCH_CONTROL_ADDR: rdata_d = ffc_q;
			cpr_pkg::PROCESSOR_STATUS_ADDR:    rdata_d = psw_q;
			default:                           rdata_d = 8'h00;
		endcase
		// flush pulses on the rising edge of the disable bit
		flush_d  = ffc_d[cpr_pkg::FFC_CACHE_DISABLE] &&
			!ffc_q[cpr_pkg::FFC_CACHE_DISABLE]; // RULE4
		bypass_d = ffc_d[cpr_pkg::FFC_CACHE_DISABLE]; // RULE4
		pref_d   = fetch_i && cache_last_i &&
			!ffc_q[cpr_pkg::FFC_PREFETCH_DISABLE] &&
			!ffc_q[cpr_pkg::FFC_CACHE_DISABLE]; // RULE5
		// alternate on contention so neither side starves
		cpu_gnt_d  = cpu_req_i && (!dma_req_i || last_dma_q); // RULE3
		dma_gnt_d  = dma_req_i && !cpu_gnt_d; // RULE3
		last_dma_d = dma_gnt_d ? 1'b1 : (cpu_gnt_d ? 1'b0 : last_dma_q);
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			for (int i = 0; i < 2; i++)
			begin
				dpl_q[i] <= cpr_pkg::REG_RESET;
				dph_q[i] <= cpr_pkg::REG_RESET;
			end
			for (int i = 0; i < 32; i++)
				bank_q[i] <= cpr_pkg::REG_RESET;
			sel_q           <= cpr_pkg::REG_RESET;
			page_q          <= cpr_pkg::REG_RESET;
			psw_q           <= cpr_pkg::REG_RESET;
			ffc_q           <= cpr_pkg::FFC_RESET;
			sfr_rdata_o     <= 8'h00;
			wr_bank_rdata_o <= 8'h00;
			external_data_move_addr_o     <= 16'h0000;
			active_ptr_o    <= 16'h0000;
			cache_flush_o   <= 1'b0;
			fetch_bypass_o  <= 1'b0;
			prefetch_o      <= 1'b0;
			cpu_gnt_o       <= 1'b0;
			dma_gnt_o       <= 1'b0;
			last_dma_q      <= 1'b0;
		end
		else
		begin
			dpl_q           <= dpl_d;
			dph_q           <= dph_d;
			bank_q          <= bank_d;
			sel_q           <= sel_d;
			page_q          <= page_d;
			psw_q           <= psw_d;
			ffc_q           <= ffc_d;
			sfr_rdata_o     <= rdata_d;
			wr_bank_rdata_o <= bank_rdata_d;
			external_data_move_addr_o     <= external_data_move_d;
			active_ptr_o    <= ptr_d;
			cache_flush_o   <= flush_d;
			fetch_bypass_o  <= bypass_d;
			prefetch_o      <= pref_d;
			cpu_gnt_o       <= cpu_gnt_d;
			dma_gnt_o       <= dma_gnt_d;
			last_dma_q      <= last_dma_d;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	parity_track_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$past(nrst_i) |-> psw_q[0] == ^$past(acc_i))
		else $error("parity bit wrong"); // RULE13
	carry_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		arith_valid_i && !(sfr_wr_i || sfr_bit_wr_i) |=>
		psw_q[7] == $past(arith_carry_i))
		else $error("carry flag wrong"); // RULE10
	half_carry_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		arith_valid_i && !(sfr_wr_i || sfr_bit_wr_i) |=>
		psw_q[6] == $past(arith_half_i))
		else $error("half carry wrong"); // RULE11
	overflow_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		arith_valid_i && !(sfr_wr_i || sfr_bit_wr_i) |=>
		psw_q[2] == $past(arith_ovf_i))
		else $error("overflow flag wrong"); // RULE12
	user_bits_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!(sfr_wr_i || sfr_bit_wr_i) |=> $stable({psw_q[5], psw_q[1]}))
		else $error("user bits changed"); // RULE14
	sw_wins_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		sfr_wr_i && !sfr_bit_wr_i &&
		sfr_addr_i == cpr_pkg::PROCESSOR_STATUS_ADDR |=>
		psw_q[7:1] == $past(sfr_wdata_i[7:1]))
		else $error("status write lost"); // RULE16
	external_data_move_page_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		external_data_move_ri_i |=> external_data_move_addr_o[15:8] == $past(page_q))
		else $error("page byte wrong"); // RULE1
	ptr_pick_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		1'b1 |=> active_ptr_o == ($past(sel_q[0]) ?
		{$past(dph_q[1]), $past(dpl_q[1])} :
		{$past(dph_q[0]), $past(dpl_q[0])}))
		else $error("pointer select wrong"); // RULE7
	no_prefetch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		ffc_q[0] |=> !prefetch_o)
		else $error("prefetch while disabled"); // RULE5
	arb_excl_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!(cpu_gnt_o && dma_gnt_o))
		else $error("arbiter double grant"); // RULE3
	dma_alone_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		dma_req_i && !cpu_req_i |=> dma_gnt_o)
		else $error("dma grant missing"); // RULE3

endmodule // cpr_regs

`default_nettype wire

// File: core/cpr_pkg.sv
package cpr_pkg;

	// ----------------------------------------
	// special-function register addresses
	// ----------------------------------------
	localparam logic [7:0] DATA_POINTER0_LOW_ADDR  = 8'h82;
	localparam logic [7:0] DATA_POINTER0_HIGH_ADDR = 8'h83;
	localparam logic [7:0] DATA_POINTER1_LOW_ADDR  = 8'h84;
	localparam logic [7:0] DATA_POINTER1_HIGH_ADDR = 8'h85;
	localparam logic [7:0] POINTER_SELECT_ADDR     = 8'h92;
	localparam logic [7:0] XDATA_PAGE_HIGH_ADDR    = 8'h93;
	localparam logic [7:0] PROCESSOR_STATUS_ADDR   = 8'hd0;
	localparam logic [7:0] FLASH_FETCH_CONTROL_ADDR = 8'hc7;

	// ----------------------------------------
	// unified window onto the working banks
	// ----------------------------------------
	localparam logic [15:0] BANK_WINDOW_BASE = 16'hff00;
	localparam logic [15:0] BANK_WINDOW_LAST = 16'hff1f;
	localparam logic [7:0]  BANK_DATA_LAST   = 8'h1f;

	// ----------------------------------------
	// status word fields
	// ----------------------------------------
	localparam int PSW_CARRY      = 7;
	localparam int PSW_HALF_CARRY = 6;
	localparam int PSW_USER_ZERO  = 5;
	localparam int PSW_BANK_HI    = 4;
	localparam int PSW_BANK_LO    = 3;
	localparam int PSW_OVERFLOW   = 2;
	localparam int PSW_USER_ONE   = 1;
	localparam int PSW_PARITY     = 0;

	// ----------------------------------------
	// fetch control and pointer select fields, reset values
	// ----------------------------------------
	localparam int FFC_CACHE_DISABLE    = 1;
	localparam int FFC_PREFETCH_DISABLE = 0;
	localparam int POINTER_SELECT_BIT   = 0;
	localparam logic [7:0] FFC_RESET    = 8'h01;
	localparam logic [7:0] REG_RESET    = 8'h00;

	// ----------------------------------------
	// memory arbiter owners
	// ----------------------------------------
	typedef enum logic [1:0] {
		CPR_OWN_IDLE,
		CPR_OWN_CPU,
		CPR_OWN_DMA
	} cpr_owner_t;

endpackage

// File: verification/cpr_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module cpr_core_model (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic cpu_gnt_i,
	input  wire logic dma_gnt_i,
	output logic      cpu_req_o,
	output logic      dma_req_o
);
	int   idle_cpu;
	int   idle_dma;
	logic gc;
	logic gd;

	initial
	begin
		cpu_req_o = 1'b0;
		dma_req_o = 1'b0;
	end

	// ----------------------------------------
	// requests held until the grant is seen
	// ----------------------------------------
	// dma waits longer so both often overlap
	always @(posedge clk_i)
	begin
		gc = cpu_gnt_i;
		gd = dma_gnt_i;
		#1;
		if (!nrst_i)
		begin
			cpu_req_o = 1'b0;
			dma_req_o = 1'b0;
			idle_cpu = 0;
			idle_dma = 0;
		end
		else
		begin
			if (cpu_req_o && gc)
			begin
				cpu_req_o = 1'b0;
				idle_cpu = 1;
			end
			else if (!cpu_req_o && idle_cpu == 0)
				cpu_req_o = 1'b1;
			else if (!cpu_req_o)
				idle_cpu--;
			if (dma_req_o && gd)
			begin
				dma_req_o = 1'b0;
				idle_dma = 2;
			end
			else if (!dma_req_o && idle_dma == 0)
				dma_req_o = 1'b1;
			else if (!dma_req_o)
				idle_dma--;
		end
	end
endmodule // cpr_core_model

`default_nettype wire

// File: verification/cpu_pointer_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_pointer_status_regs_test;
	logic        clk_i, nrst_i, sfr_wr_i, sfr_bit_wr_i, arith_valid_i;
	logic        arith_carry_i, arith_half_i, arith_ovf_i, external_data_move_ri_i;
	logic        ri_sel_i, ptr_inc_i, wr_bank_wr_i, fetch_i, cache_last_i;
	logic        cpu_req_i, dma_req_i, cpu_gnt_o, dma_gnt_o;
	logic        cache_flush_o, fetch_bypass_o, prefetch_o;
	logic [2:0]  sfr_bit_i;
	logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, acc_i;
	logic [7:0]  wr_bank_wdata_i, wr_bank_rdata_o;
	logic [15:0] external_data_move_addr_o, active_ptr_o, wr_bank_addr_i;
	int          err_total, n_tests, n_flush, n_pref, n_cg, n_dg;
	int          i, j, k;
	int          m[256];
	int          bank[32];
	logic [31:0] seed = 32'h8de2c0eb;

	cpr_regs cpr_regs_inst (.*);
	cpr_core_model cpr_core_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.cpu_gnt_i(cpu_gnt_o), .dma_gnt_i(dma_gnt_o),
		.cpu_req_o(cpu_req_i), .dma_req_o(dma_req_i));

	always #5 clk_i = ~clk_i;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function logic [7:0] rnd;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// parity bit never stored, always from the accumulator
	function logic [7:0] ex(input logic [7:0] a);
		return (a == 8'hd0) ? 8'((m[a] & 'hfe) | ^acc_i) : 8'(m[a]);
	endfunction

	function logic [15:0] ptr;
		j = (m[8'h92] & 1) * 2;
		return {8'(m[8'h83 + j]), 8'(m[8'h82 + j])};
	endfunction

	task tick;
		@(posedge clk_i);
		#1;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		tick;
		sfr_wr_i = 1'b0;
		if (a inside {8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'h93, 8'hc7, 8'hd0})
			m[a] = d;
	endtask

	task rd(input logic [7:0] a);
		sfr_addr_i = a;
		tick;
		chk(16'(sfr_rdata_o), 16'(ex(a)));
	endtask

	task final_report;
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// pulses and grants counted on every rising edge
	always @(posedge clk_i)
	begin
		n_flush += int'(cache_flush_o === 1'b1);
		n_pref += int'(prefetch_o === 1'b1);
		n_cg += int'(cpu_gnt_o === 1'b1);
		n_dg += int'(dma_gnt_o === 1'b1);
		if (cpu_gnt_o === 1'b1 && dma_gnt_o === 1'b1)
			chk(16'h1, 16'h0);
	end

	initial
	begin
		#100000;
		err_total++;
		final_report;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		{nrst_i, sfr_wr_i, sfr_bit_wr_i, arith_valid_i, arith_carry_i} = '0;
		{arith_half_i, arith_ovf_i, external_data_move_ri_i, ri_sel_i, ptr_inc_i} = '0;
		{wr_bank_wr_i, fetch_i, cache_last_i, sfr_bit_i, acc_i} = '0;
		{sfr_addr_i, sfr_wdata_i, wr_bank_wdata_i, wr_bank_addr_i} = '0;
		m[8'hc7] = 1;
		repeat (8) tick;
		nrst_i = 1'b1;
		foreach (m[a])
			if (a >= 8'h80)
				rd(8'(a));
		wr(8'h90, 8'h5a);
		rd(8'h90);
		for (k = 0; k < 6; k++)
		begin
			wr(8'h82 + 8'(k % 4), rnd());
			wr(8'h92, (rnd() & 8'hfe) | 8'(k % 2));
			rd(8'h82 + 8'(k % 4));
			tick;
			chk(active_ptr_o, ptr());
		end
		wr(8'h84, 8'hff);
		wr(8'h85, 8'hff);
		ptr_inc_i = 1'b1;
		tick;
		ptr_inc_i = 1'b0;
		k = (ptr() + 1) & 'hffff;
		m[8'h83 + j] = k >> 8;
		m[8'h82 + j] = k & 255;
		tick;
		chk(active_ptr_o, ptr());
		rd(8'h85);
		// fill through one mapping, read through the other
		for (i = 0; i < 32; i++)
		begin
			bank[i] = rnd();
			wr_bank_addr_i = (i % 2) ? 16'hff00 + 16'(i) : 16'(i);
			wr_bank_wdata_i = 8'(bank[i]);
			wr_bank_wr_i = 1'b1;
			tick;
			wr_bank_wr_i = 1'b0;
		end
		for (i = 0; i <= 32; i++)
		begin
			wr_bank_addr_i = (i % 2) ? 16'(i) : 16'hff00 + 16'(i);
			tick;
			chk(16'(wr_bank_rdata_o), (i < 32) ? 16'(bank[i]) : 16'h0);
		end
		for (k = 0; k < 8; k++)
		begin
			wr(8'hd0, 8'((k >> 1) << 3));
			wr(8'h93, rnd());
			ri_sel_i = k[0];
			external_data_move_ri_i = 1'b1;
			tick;
			external_data_move_ri_i = 1'b0;
			chk(external_data_move_addr_o, {8'(m[8'h93]), 8'(bank[(k >> 1) * 8 + k % 2])});
		end
		wr(8'hd0, 8'h22);
		for (k = 0; k < 16; k++)
		begin
			acc_i = rnd();
			{arith_carry_i, arith_half_i, arith_ovf_i} = 3'(rnd());
			arith_valid_i = 1'b1;
			tick;
			arith_valid_i = 1'b0;
			m[8'hd0] = (m[8'hd0] & 'h3a) | (arith_carry_i << 7)
				| (arith_half_i << 6) | (arith_ovf_i << 2);
			rd(8'hd0);
		end
		for (k = 0; k < 8; k++)
		begin
			sfr_addr_i = 8'hd0;
			sfr_bit_i = 3'(k);
			sfr_wdata_i = 8'h01 & ~(ex(8'hd0) >> k);
			sfr_bit_wr_i = 1'b1;
			tick;
			sfr_bit_wr_i = 1'b0;
			if (k != 0)
				m[8'hd0] ^= 1 << k;
			rd(8'hd0);
		end
		{arith_carry_i, arith_half_i, arith_ovf_i, arith_valid_i} = 4'hf;
		wr(8'hd0, 8'h01);
		arith_valid_i = 1'b0;
		rd(8'hd0);
		k = n_flush;
		wr(8'hc7, 8'hfe);
		repeat (2) tick;
		chk(16'(n_flush - k), 16'h1);
		rd(8'hc7);
		for (k = 0; k < 8; k++)
		begin
			wr(8'hc7, 8'(k % 4));
			cache_last_i = k[2];
			fetch_i = 1'b1;
			j = n_pref;
			tick;
			fetch_i = 1'b0;
			repeat (2) tick;
			chk(16'(n_pref - j), 16'(k == 4));
			chk(16'(fetch_bypass_o), 16'(k[1]));
		end
		chk(16'(n_cg > 0 && n_dg > 0), 16'h1);
		final_report;
	end
endmodule // cpu_pointer_status_regs_test

`default_nettype wire
